// ---- common/eil_map.svh ----
// register offsets, field positions, reset values and vector locations of the external
// interrupt latch
// assumes a 32-bit classic wishbone bus with word-aligned registers
//
// Contract
// [RULE1] falling pin edge sets the latch
// [RULE2] vector fetch acknowledge clears the latch
// [RULE3] writing one to clear strobe clears latch
// [RULE4] reset clears latch and sensitivity bit
// [RULE5] edge mode: acknowledge clears at once
// [RULE6] level mode: needs acknowledge and pin high
// [RULE7] level mode: pending while pin low, any order
// [RULE8] request block bit withholds the request
// [RULE9] pending flag ignores request block bit
// [RULE10] clear strobe write-only, reads zero, reset clear
// [RULE11] edge after acknowledge sets latch again
// [RULE12] serviced request uses vector pair high/low
// [RULE13] break with allow zero blocks software clear
// [RULE14] break with allow one clears, stays cleared
// [RULE15] request block bit read/write, reset zero
// [RULE16] sensitivity bit read/write, one adds level
// [RULE17] pin level visible to branch instructions
// [RULE18] software masks in level mode service routine
// [RULE19] synchronise pin, detect edge by comparison
`ifndef EIL_MAP_SVH
`define EIL_MAP_SVH

`define EIL_ADDR_SCR        8'h00
`define EIL_ADDR_EVT_STAT   8'h04
`define EIL_ADDR_EVT_CLR    8'h08
`define EIL_ADDR_EVT_EN     8'h0C
`define EIL_ADDR_BRK_CTL    8'h10

`define EIL_SCR_MODE_BIT    0
`define EIL_SCR_MASK_BIT    1
`define EIL_SCR_ACK_BIT     2
`define EIL_SCR_FLAG_BIT    3
`define EIL_SCR_PIN_BIT     4
`define EIL_BRK_ALLOW_BIT   0
`define EIL_EVT_LATCH_BIT   0

`define EIL_SCR_RESET       8'h00
`define EIL_VEC_HIGH        16'hFFFA
`define EIL_VEC_LOW         16'hFFFB

`endif

// ---- common/eil_pkg.sv ----
// types shared by the external interrupt latch
// assumes eil_map.svh for numeric constants
package eil_pkg;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } eil_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } eil_wb_rsp_t;

   typedef struct packed {
      logic        pin_meta;
      logic        pin_sync;
      logic        pin_prev;
      logic        latch;
      logic        mode;
      logic        mask;
      logic        brk_allow;
      logic        evt_stat;
      logic        evt_en;
      logic        irq;
      logic        evt_irq;
      logic        pin_level;
      logic        ack;
      logic [31:0] rdat;
   } eil_state_t;

endpackage : eil_pkg

// ---- logic/eil_latch.sv ----
// external interrupt latch: one active-low pin, edge or edge-and-level sensitive,
// wishbone classic slave for its registers
// assumes pin is asynchronous; vector fetch acknowledge and break state come from the cpu
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "eil_map.svh"

module eil_latch (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // register bus
   input  wire eil_pkg::eil_wb_req_t wb_req_i,
   output eil_pkg::eil_wb_rsp_t      wb_rsp_o,
   // pin and cpu
   input  wire logic                 ext_int_pin_n_i,
   input  wire logic                 vec_fetch_ack_i,
   input  wire logic                 break_state_i,
   output logic                      irq_req_o,
   output logic                      pin_level_o,
   output logic                      event_irq_o
);
   import eil_pkg::*;

   // vector pair the cpu uses when servicing this request
   localparam logic [15:0] VEC_HIGH = `EIL_VEC_HIGH; // RULE12
   localparam logic [15:0] VEC_LOW  = `EIL_VEC_LOW;  // RULE12

   eil_state_t st_reg;
   eil_state_t st_next;

   logic access;
   logic wr;
   logic sw_ack;
   logic ack_any;
   logic fall;
   logic pending;
   logic pending_next;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      access  = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;
      wr      = access & wb_req_i.we & wb_req_i.sel[0];
      st_next.pin_meta = ext_int_pin_n_i;             // RULE19
      st_next.pin_sync = st_reg.pin_meta;             // RULE19
      st_next.pin_prev = st_reg.pin_sync;
      fall = st_reg.pin_prev & ~st_reg.pin_sync;      // RULE19
      // level mode keeps the request pending while the pin is low
      pending = st_reg.latch | (st_reg.mode & ~st_reg.pin_sync); // RULE6 RULE7
      sw_ack = wr && wb_req_i.adr == `EIL_ADDR_SCR
               && wb_req_i.dat[`EIL_SCR_ACK_BIT]
               && (!break_state_i || st_reg.brk_allow); // RULE3 RULE13 RULE14
      ack_any = sw_ack | vec_fetch_ack_i;             // RULE2
      if (fall) begin
         st_next.latch = 1'b1;                        // RULE1 RULE11
      end else if (ack_any) begin
         st_next.latch = 1'b0;                        // RULE5
      end
      if (fall) begin
         st_next.evt_stat = 1'b1;
      end
      if (wr && wb_req_i.adr == `EIL_ADDR_SCR) begin
         st_next.mode = wb_req_i.dat[`EIL_SCR_MODE_BIT]; // RULE16
         st_next.mask = wb_req_i.dat[`EIL_SCR_MASK_BIT]; // RULE15
      end
      if (wr && wb_req_i.adr == `EIL_ADDR_EVT_CLR && wb_req_i.dat[`EIL_EVT_LATCH_BIT]
          && !fall) begin
         st_next.evt_stat = 1'b0;
      end
      if (wr && wb_req_i.adr == `EIL_ADDR_EVT_EN) begin
         st_next.evt_en = wb_req_i.dat[`EIL_EVT_LATCH_BIT];
      end
      if (wr && wb_req_i.adr == `EIL_ADDR_BRK_CTL) begin
         st_next.brk_allow = wb_req_i.dat[`EIL_BRK_ALLOW_BIT];
      end
      // acknowledge and pin return may come in either order
      pending_next      = st_next.latch | (st_next.mode & ~st_next.pin_sync); // RULE6 RULE7
      st_next.irq       = pending_next & ~st_next.mask; // RULE8
      st_next.evt_irq   = st_next.evt_stat & st_next.evt_en;
      st_next.pin_level = st_reg.pin_sync;               // RULE17
      st_next.ack       = access;
      st_next.rdat      = 32'h0000_0000;
      if (access && !wb_req_i.we) begin
         unique case (wb_req_i.adr)
            `EIL_ADDR_SCR: begin
               st_next.rdat[`EIL_SCR_MODE_BIT] = st_reg.mode;
               st_next.rdat[`EIL_SCR_MASK_BIT] = st_reg.mask;
               st_next.rdat[`EIL_SCR_ACK_BIT]  = 1'b0;     // RULE10
               st_next.rdat[`EIL_SCR_FLAG_BIT] = pending; // RULE9
               st_next.rdat[`EIL_SCR_PIN_BIT]  = st_reg.pin_sync;
            end
            `EIL_ADDR_EVT_STAT: st_next.rdat[0] = st_reg.evt_stat;
            `EIL_ADDR_EVT_EN:   st_next.rdat[0] = st_reg.evt_en;
            `EIL_ADDR_BRK_CTL:  st_next.rdat[0] = st_reg.brk_allow;
            default:            st_next.rdat = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg          <= '0;  // RULE4 RULE10 RULE15
         // the pin is still sampled, so a level held low through reset is no edge
         st_reg.pin_meta <= ext_int_pin_n_i; // RULE4
         st_reg.pin_sync <= st_reg.pin_meta;
         st_reg.pin_prev <= st_reg.pin_sync;
         st_reg.pin_level <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_rsp_o.ack = st_reg.ack;
   assign wb_rsp_o.dat = st_reg.rdat;
   assign irq_req_o    = st_reg.irq;
   assign pin_level_o  = st_reg.pin_level;
   assign event_irq_o  = st_reg.evt_irq;

endmodule : eil_latch

// ---- test/eil_latch_checker.sv ----
// port assertions for the external interrupt latch
// assumes one clock with a synchronous active-high reset
`timescale 1ns/1ps
`include "eil_map.svh"
module eil_latch_checker (
   input wire logic                 clk_i, rst_i, ext_int_pin_n_i, vec_fetch_ack_i,
   input wire logic                 break_state_i, irq_req_o, pin_level_o, event_irq_o,
   input wire eil_pkg::eil_wb_req_t wb_req_i,
   input wire eil_pkg::eil_wb_rsp_t wb_rsp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = wb_req_i.cyc && wb_req_i.stb;
   wire logic ack = wb_rsp_o.ack;
   wire logic scr = wb_req_i.adr == `EIL_ADDR_SCR;
   wire logic wr0 = ack && wb_req_i.we && wb_req_i.sel[0];
   ack_width_a: assert property (ack |=> !ack) else $error("ack too long");
   ack_delay_a: assert property (req && !ack |=> ack) else $error("ack late");
   ack_idle_a: assert property (!req |=> !ack) else $error("ack without request");
   strobe_zero_a: assert property (ack && !wb_req_i.we && scr |-> !wb_rsp_o.dat[2])
      else $error("clear strobe reads one");
   mask_gate_a: assert property (wr0 && scr && wb_req_i.dat[1] |=> ##1 !irq_req_o)
      else $error("masked request shown");
   event_gate_a: assert property (wr0 && wb_req_i.adr == `EIL_ADDR_EVT_EN && !wb_req_i.dat[0]
      |=> ##1 !event_irq_o) else $error("disabled event interrupt");
   pin_low_a: assert property ((!ext_int_pin_n_i) [*5] |-> !pin_level_o)
      else $error("pin level not low");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !irq_req_o && pin_level_o
      && !event_irq_o && !ack) else $error("reset values");
endmodule : eil_latch_checker
bind eil_latch eil_latch_checker u_chk (.clk_i, .rst_i, .ext_int_pin_n_i, .vec_fetch_ack_i,
   .break_state_i, .irq_req_o, .pin_level_o, .event_irq_o, .wb_req_i, .wb_rsp_o);

// ---- test/eil_pin_src.sv ----
// pin source: idles high as the pull-up holds it, drives timed low pulses
// assumes go_i lasts one cycle
`timescale 1ns/1ps
module eil_pin_src (
   input  wire logic       clk_i, go_i,
   input  wire logic [7:0] len_i,
   output logic            pin_n_o
);
   logic [7:0] cnt_reg = 8'h00;
   always @(posedge clk_i) cnt_reg <= go_i ? len_i : cnt_reg - 8'(cnt_reg != 8'h00);
   assign pin_n_o = cnt_reg == 8'h00;
endmodule : eil_pin_src

// ---- test/tb_external_interrupt_latch.sv ----
// bench for the external interrupt latch: bus tasks, pin source, self checks
// assumes eil_latch, eil_pin_src and the bound checker
`timescale 1ns/1ps
`include "eil_map.svh"
module tb_external_interrupt_latch;
   import eil_pkg::*;
   localparam logic [7:0] a_scr = `EIL_ADDR_SCR, a_st = `EIL_ADDR_EVT_STAT,
      a_clr = `EIL_ADDR_EVT_CLR, a_en = `EIL_ADDR_EVT_EN, a_brk = `EIL_ADDR_BRK_CTL;
   logic clk_i = 1'b0, rst_i = 1'b1, vf = 1'b0, brk = 1'b0, go = 1'b0, pin, irq, lvl, ev;
   logic [7:0]  len = 8'h04;
   logic [31:0] q;
   eil_wb_req_t rq = '0;
   eil_wb_rsp_t rs;
   int failures = 0, checked = 0;
   eil_latch u_dut (.clk_i, .rst_i, .wb_req_i(rq), .wb_rsp_o(rs), .ext_int_pin_n_i(pin),
      .vec_fetch_ack_i(vf), .break_state_i(brk), .irq_req_o(irq), .pin_level_o(lvl),
      .event_irq_o(ev));
   eil_pin_src u_src (.clk_i, .go_i(go), .len_i(len), .pin_n_o(pin));
   initial forever #2.5 clk_i = ~clk_i;
   initial begin repeat (3000) @(posedge clk_i); failures++; finish_test(); end
   function automatic logic [31:0] scr(logic md, mk, fl); return {28'h000_0001, fl, 1'b0, mk, md};
   endfunction : scr
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin failures++; $display("mismatch %s expected %h seen %h", n, e, g); end
   endtask : cmp
   task automatic flag(string n, logic e, logic g); cmp(n, {31'h0, e}, {31'h0, g}); endtask : flag
   task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
      rq <= '{1'b1, 1'b1, we, a, 4'h1, d};
      do @(posedge clk_i); while (rs.ack !== 1'b1);
      q = rs.dat;
      rq <= '0;
      repeat (3) @(posedge clk_i);
   endtask : wb
   task automatic w(logic [7:0] a, logic [31:0] d); wb(1'b1, a, d); endtask : w
   task automatic rd(logic [7:0] a, logic [31:0] e); wb(1'b0, a, 0); cmp("read", e, q); endtask : rd
   // one falling edge, low for n cycles
   task automatic pulse(logic [7:0] n);
      len <= n; go <= 1'b1; @(posedge clk_i); go <= 1'b0; repeat (12) @(posedge clk_i);
   endtask : pulse
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   initial begin
      void'($urandom(32'h3eae));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(a_scr, scr(0, 0, 0));
      w(a_scr, 32'h3); rd(a_scr, scr(1, 1, 0));
      flag("pin", 1'b1, lvl);
      w(a_scr, 32'h2); pulse(8'h4 + 8'($urandom % 4)); flag("irq", 1'b0, irq);
      rd(a_scr, scr(0, 1, 1));
      w(a_scr, 32'h0); flag("irq", 1'b1, irq);
      w(a_scr, 32'h4); rd(a_scr, scr(0, 0, 0));
      pulse(8'h5); flag("irq", 1'b1, irq);
      vf <= 1'b1; @(posedge clk_i); vf <= 1'b0; repeat (3) @(posedge clk_i);
      flag("irq", 1'b0, irq);
      pulse(8'h28); w(a_scr, 32'h4); flag("irq", 1'b0, irq);
      $display("test edge mode done");
      repeat (40) @(posedge clk_i);
      w(a_scr, 32'h1); pulse(8'h3c); w(a_scr, 32'h5); flag("irq", 1'b1, irq);
      w(a_scr, 32'h7); flag("irq", 1'b0, irq);
      rd(a_scr, scr(1, 1, 1) & ~32'h0000_0010);
      repeat (60) @(posedge clk_i); w(a_scr, 32'h1); flag("irq", 1'b0, irq);
      brk <= 1'b1; pulse(8'h5); w(a_scr, 32'h5); flag("irq", 1'b1, irq);
      w(a_brk, 32'h1); w(a_scr, 32'h5); brk <= 1'b0; rd(a_scr, scr(1, 0, 0));
      $display("test level and break done");
      w(a_clr, 32'h1); w(a_en, 32'h1); pulse(8'h5); flag("event", 1'b1, ev);
      rd(a_st, 32'h1); w(a_en, 32'h0); flag("event", 1'b0, ev); rd(8'h14, 32'h0);
      $display("test events done");
      w(a_scr, 32'h1); pulse(8'h50); rst_i <= 1'b1; repeat (12) @(posedge clk_i);
      rst_i <= 1'b0; repeat (8) @(posedge clk_i); flag("irq", 1'b0, irq);
      rd(a_scr, 32'h0000_0000);
      $display("test reset with pin low done");
      finish_test();
   end
endmodule : tb_external_interrupt_latch
